// >>> logic/sds_step_sequencer.sv
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/100ps

// Function
// RULE1 - With double-edge set both step edges count, otherwise only rising edges.
// RULE2 - Step and direction pins pass two flip-flops before any use.
// RULE3 - Controller keeps step rate below half clock, quarter with double edges.
// RULE4 - A 1024-entry sine table over four full steps gives both coil currents.
// RULE5 - Each step adds the width with direction 0, subtracts with direction 1.
// RULE6 - Step width is one at finest resolution, doubling up to 256.
// RULE7 - Resolution may change anytime; coarser snaps counter to nearest valid position.
// RULE8 - Full steps visit only 128, 384, 640 and 896.
// RULE9 - Half steps start at 64, spaced 128 apart.
// RULE10 - Quarter steps start at 32, spaced 64 apart.
// RULE11 - Interpolation fills each step interval with 2 to 256 single microsteps.
// RULE12 - Interpolation runs only while its chopper enable bit is set.
// RULE13 - Microstep spacing is the previous step period split into equal parts.
// RULE14 - No step event for 2^20 clocks sets the standstill flag.
// RULE15 - Fast-standstill bit shortens that timeout to 2^18 clocks.
// RULE16 - The next active step edge clears the standstill flag.
// RULE17 - At standstill the current scale switches to the holding current.
// RULE18 - New rate used after one measured interval; pending microsteps are dropped.
// RULE19 - Controller uses double edges only with a 50% duty step signal.
// RULE20 - The 10-bit microstep counter wraps modulo 1024 both ways.
module sds_step_sequencer
    import sds_pkg::*;
#(
    parameter int STANDSTILL_CLKS      = SDS_STANDSTILL_CLKS,
    parameter int FAST_STANDSTILL_CLKS = SDS_FAST_STANDSTILL_CLKS
)
(
    // Clock and reset.
    input  wire logic        mclk,
    input  wire logic        rstn,
    // Register port.
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic [31:0]      regRdata,
    // Step and direction pins.
    input  wire logic        stepPin,
    input  wire logic        dirPin,
    // Motor side.
    output sds_coil_t        coilCurrentA,
    output sds_coil_t        coilCurrentB,
    output sds_scale_t       currentScale,
    output sds_pos_t         microPosition,
    output logic             standstill
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [3:0] resShift(input logic [3:0] res);
        return (res > SDS_RES_FULL) ? SDS_RES_FULL : res;
    endfunction : resShift

    function automatic sds_pos_t stepWidth(input logic [3:0] res);
        return 10'h1 << resShift(res);
    endfunction : stepWidth

    // Nearest valid position: the middle of the cell of the step width.
    function automatic sds_pos_t snapPos(input sds_pos_t pos, input logic [3:0] res);
        sds_pos_t w;
        w = stepWidth(res);
        if (w == 10'h1) begin
            return pos;
        end
        return (pos & ~(w - 10'h1)) | (w >> 1);
    endfunction : snapPos

    // ****************************************
    // Registers
    // ****************************************
    logic [31:0] globalConfig_reg;
    logic [31:0] chopperConfig_reg;
    logic [31:0] currentConfig_reg;
    logic [31:0] regRdata_reg;
    logic [31:0] readMux;

    logic       fastStandstill;
    logic [3:0] resolution;
    logic       interpEnable;
    logic       doubleEdge;
    sds_scale_t holdCurrentScale;
    sds_scale_t runCurrentScale;

    assign fastStandstill   = globalConfig_reg[SDS_GLOBAL_FAST_BIT];
    assign resolution       = chopperConfig_reg[SDS_CHOP_RES_LSB +: 4];
    assign interpEnable     = chopperConfig_reg[SDS_CHOP_INTERP_BIT];
    assign doubleEdge       = chopperConfig_reg[SDS_CHOP_DEDGE_BIT];
    assign holdCurrentScale = currentConfig_reg[SDS_CUR_HOLD_LSB +: 5];
    assign runCurrentScale  = currentConfig_reg[SDS_CUR_RUN_LSB +: 5];

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            globalConfig_reg  <= SDS_GLOBAL_RST;
            chopperConfig_reg <= SDS_CHOPPER_RST;
            currentConfig_reg <= SDS_CURRENT_RST;
        end else if (regWrite) begin
            case (regAddr)
                SDS_ADDR_GLOBAL:  globalConfig_reg  <= regWdata;
                SDS_ADDR_CHOPPER: chopperConfig_reg <= regWdata;
                SDS_ADDR_CURRENT: currentConfig_reg <= regWdata;
                default:          ;
            endcase
        end
    end

    sds_coil_if coilBus ();
    sds_pos_t   msCount_reg;
    logic       stst_reg;

    always_comb begin
        readMux = 32'h0;
        case (regAddr)
            SDS_ADDR_GLOBAL:  readMux = globalConfig_reg;
            SDS_ADDR_CHOPPER: readMux = chopperConfig_reg;
            SDS_ADDR_CURRENT: readMux = currentConfig_reg;
            SDS_ADDR_STATUS: begin
                readMux[9:0]                = msCount_reg;
                readMux[SDS_STAT_STILL_BIT] = stst_reg;
            end
            SDS_ADDR_COIL: begin
                readMux[8:0]                    = coilBus.coilA;
                readMux[SDS_COIL_B_LSB +: 9]    = coilBus.coilB;
            end
            default:          readMux = 32'h0;
        endcase
    end

    // Read data stands in the cycle after the strobe only.
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            regRdata_reg <= 32'h0;
        end else begin
            regRdata_reg <= regRead ? readMux : 32'h0;
        end
    end

    // ****************************************
    // Pin synchronisers and edge detect
    // ****************************************
    logic stepSync1_reg;
    logic stepSync2_reg;
    logic stepPrev_reg;
    logic dirSync1_reg;
    logic dirSync2_reg;
    logic stepEvent;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            stepSync1_reg <= 1'b0;
            stepSync2_reg <= 1'b0;
            stepPrev_reg  <= 1'b0;
            dirSync1_reg  <= 1'b0;
            dirSync2_reg  <= 1'b0;
        end else begin
            stepSync1_reg <= stepPin; // see RULE2
            stepSync2_reg <= stepSync1_reg; // see RULE2
            stepPrev_reg  <= stepSync2_reg;
            dirSync1_reg  <= dirPin; // see RULE2
            dirSync2_reg  <= dirSync1_reg; // see RULE2
        end
    end

    // Double-edge stepping halves the usable step rate, as each level must last two clocks.
    assign stepEvent = doubleEdge ? (stepSync2_reg ^ stepPrev_reg)
                                  : (stepSync2_reg & ~stepPrev_reg); // see RULE1

    // ****************************************
    // Step period and standstill
    // ****************************************
    sds_period_t periodCnt_reg;
    sds_period_t lastPeriod_reg;
    sds_period_t limitSel;

    assign limitSel = fastStandstill ? sds_period_t'(FAST_STANDSTILL_CLKS)
                                     : sds_period_t'(STANDSTILL_CLKS); // see RULE15

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            periodCnt_reg  <= '0;
            lastPeriod_reg <= sds_period_t'(STANDSTILL_CLKS);
        end else if (stepEvent) begin
            periodCnt_reg  <= '0;
            lastPeriod_reg <= periodCnt_reg + 21'h1; // see RULE13
        end else if (periodCnt_reg < sds_period_t'(STANDSTILL_CLKS)) begin
            periodCnt_reg  <= periodCnt_reg + 21'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            stst_reg <= 1'b0;
        end else if (stepEvent) begin
            stst_reg <= 1'b0; // see RULE16
        end else if (periodCnt_reg >= limitSel) begin
            stst_reg <= 1'b1; // see RULE14
        end
    end

    sds_scale_t currentScale_reg;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            currentScale_reg <= '0;
        end else begin
            currentScale_reg <= stst_reg ? holdCurrentScale : runCurrentScale; // see RULE17
        end
    end

    // ****************************************
    // Microstep counter and interpolator
    // ****************************************
    logic [3:0]  resPrev_reg;
    sds_pos_t    target_reg;
    logic [8:0]  pending_reg;
    logic        moveDown_reg;
    sds_period_t subCnt_reg;
    sds_period_t subInterval;
    logic        resCoarser;
    logic        interpStep;
    logic        microTick;

    assign resCoarser  = resShift(resolution) > resShift(resPrev_reg);
    assign interpStep  = interpEnable && (resShift(resolution) != 4'h0); // see RULE12
    assign subInterval = lastPeriod_reg >> resShift(resolution); // see RULE13
    assign microTick   = (pending_reg != 9'h0) && ((subCnt_reg + 21'h1) >= subInterval);

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            resPrev_reg <= 4'h0;
        end else begin
            resPrev_reg <= resolution;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            subCnt_reg <= '0;
        end else if (stepEvent || microTick) begin
            subCnt_reg <= '0;
        end else if (pending_reg != 9'h0) begin
            subCnt_reg <= subCnt_reg + 21'h1;
        end
    end

    // Dropping the leftovers makes a visible angle jump, but keeps the following
    // microsteps evenly spaced instead of racing to catch up.
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            msCount_reg  <= '0;
            target_reg   <= '0;
            pending_reg  <= 9'h0;
            moveDown_reg <= 1'b0;
        end else if (resCoarser) begin
            msCount_reg <= snapPos(msCount_reg, resolution); // see RULE7 RULE8 RULE9 RULE10
            target_reg  <= snapPos(msCount_reg, resolution); // see RULE7
            pending_reg <= 9'h0;
        end else if (stepEvent) begin
            moveDown_reg <= dirSync2_reg;
            if (interpStep) begin
                msCount_reg <= target_reg; // see RULE18
                target_reg  <= dirSync2_reg ? target_reg - stepWidth(resolution)
                                            : target_reg + stepWidth(resolution); // see RULE5 RULE20
                pending_reg <= 9'h1 << resShift(resolution); // see RULE11
            end else begin
                msCount_reg <= dirSync2_reg ? msCount_reg - stepWidth(resolution)
                                            : msCount_reg + stepWidth(resolution); // see RULE5 RULE6 RULE20
                target_reg  <= dirSync2_reg ? msCount_reg - stepWidth(resolution)
                                            : msCount_reg + stepWidth(resolution);
                pending_reg <= 9'h0;
            end
        end else if (!interpStep && pending_reg != 9'h0) begin
            msCount_reg <= target_reg; // see RULE12
            pending_reg <= 9'h0;
        end else if (microTick) begin
            msCount_reg <= moveDown_reg ? msCount_reg - 10'h1 : msCount_reg + 10'h1; // see RULE11 RULE20
            pending_reg <= pending_reg - 9'h1;
        end
    end

    assign coilBus.position = msCount_reg; // see RULE4

    sds_sine_table u_table (
        .mclk    (mclk),
        .rstn    (rstn),
        .coilBus (coilBus.table_side)
    );

    // ****************************************
    // Outputs
    // ****************************************
    assign regRdata      = regRdata_reg;
    assign coilCurrentA  = coilBus.coilA;
    assign coilCurrentB  = coilBus.coilB;
    assign currentScale  = currentScale_reg;
    assign microPosition = msCount_reg;
    assign standstill    = stst_reg;

    // ****************************************
    // Assertions
    // ****************************************
    AST_PIN_SYNC: assert property (@(posedge mclk) disable iff (!rstn) // see RULE2
        ##2 (stepSync2_reg == $past(stepPin, 2)) && (dirSync2_reg == $past(dirPin, 2)))
        else $error("Step or direction not delayed by two flops.");

    AST_SINGLE_EDGE: assert property (@(posedge mclk) disable iff (!rstn) // see RULE1
        (!doubleEdge && $fell(stepSync2_reg)) |-> !stepEvent)
        else $error("Falling step edge counted without double-edge mode.");

    AST_DOUBLE_EDGE: assert property (@(posedge mclk) disable iff (!rstn) // see RULE1
        (doubleEdge && $fell(stepSync2_reg)) |-> stepEvent)
        else $error("Falling step edge ignored in double-edge mode.");

    AST_STEP_MOVE: assert property (@(posedge mclk) disable iff (!rstn) // see RULE5
        (stepEvent && !resCoarser && !interpStep) |=>
        msCount_reg == ($past(dirSync2_reg) ? $past(msCount_reg) - stepWidth($past(resolution))
                                             : $past(msCount_reg) + stepWidth($past(resolution))))
        else $error("Counter did not move by the step width.");

    AST_SNAP: assert property (@(posedge mclk) disable iff (!rstn) // see RULE7
        (resCoarser && resShift(resolution) != 4'h0) ##1 1'b1 |->
        (msCount_reg & (stepWidth($past(resolution)) - 10'h1)) == (stepWidth($past(resolution)) >> 1))
        else $error("Counter not snapped to a valid position.");

    AST_FULL_POS: assert property (@(posedge mclk) disable iff (!rstn) // see RULE8
        (resCoarser && resShift(resolution) == SDS_RES_FULL) |=> msCount_reg[7:0] == 8'h80)
        else $error("Full step position off the 45 degree points.");

    AST_STILL_SET: assert property (@(posedge mclk) disable iff (!rstn) // see RULE14
        (periodCnt_reg == limitSel - 21'h1 && !stepEvent) ##1 !stepEvent |=> stst_reg)
        else $error("Standstill not flagged at the timeout.");

    AST_STILL_CLEAR: assert property (@(posedge mclk) disable iff (!rstn) // see RULE16
        (stst_reg && stepEvent) |=> !stst_reg)
        else $error("Standstill not cleared by a step edge.");

    AST_HOLD_CUR: assert property (@(posedge mclk) disable iff (!rstn) // see RULE17
        $rose(stst_reg) ##1 $stable(holdCurrentScale) |-> currentScale_reg == holdCurrentScale)
        else $error("Holding current not applied at standstill.");

    AST_DROP_PENDING: assert property (@(posedge mclk) disable iff (!rstn) // see RULE18
        (stepEvent && interpStep && !resCoarser) |=> msCount_reg == $past(target_reg))
        else $error("Pending microsteps not dropped on a new step.");

    AST_MICRO_TICK: assert property (@(posedge mclk) disable iff (!rstn) // see RULE11
        (microTick && interpStep && !stepEvent && !resCoarser) |=>
        (msCount_reg - $past(msCount_reg) == 10'h1) || ($past(msCount_reg) - msCount_reg == 10'h1))
        else $error("Interpolated microstep not a single entry.");

endmodule : sds_step_sequencer

// >>> logic/sds_pkg.sv
package sds_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] SDS_ADDR_GLOBAL  = 8'h00;
    localparam logic [7:0] SDS_ADDR_CHOPPER = 8'h04;
    localparam logic [7:0] SDS_ADDR_CURRENT = 8'h08;
    localparam logic [7:0] SDS_ADDR_STATUS  = 8'h0c;
    localparam logic [7:0] SDS_ADDR_COIL    = 8'h10;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int SDS_GLOBAL_FAST_BIT  = 0;
    localparam int SDS_CHOP_RES_LSB     = 24;
    localparam int SDS_CHOP_INTERP_BIT  = 28;
    localparam int SDS_CHOP_DEDGE_BIT   = 29;
    localparam int SDS_CUR_HOLD_LSB     = 0;
    localparam int SDS_CUR_RUN_LSB      = 8;
    localparam int SDS_STAT_STILL_BIT   = 16;
    localparam int SDS_COIL_B_LSB       = 16;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [31:0] SDS_GLOBAL_RST  = 32'h0000_0000;
    localparam logic [31:0] SDS_CHOPPER_RST = 32'h1000_0000;
    localparam logic [31:0] SDS_CURRENT_RST = 32'h0000_1f08;

    // ****************************************
    // Counts and widths
    // ****************************************
    localparam int         SDS_STANDSTILL_CLKS      = 2 ** 20;
    localparam int         SDS_FAST_STANDSTILL_CLKS = 2 ** 18;
    localparam logic [3:0] SDS_RES_FULL             = 4'h8;
    localparam int         SDS_TABLE_QUARTER        = 256;

    typedef logic [9:0]         sds_pos_t;
    typedef logic signed [8:0]  sds_coil_t;
    typedef logic [20:0]        sds_period_t;
    typedef logic [4:0]         sds_scale_t;

endpackage : sds_pkg

// >>> logic/sds_coil_if.sv
`timescale 1ns/100ps

interface sds_coil_if;
    import sds_pkg::*;
    sds_pos_t  position;
    sds_coil_t coilA;
    sds_coil_t coilB;

    modport table_side (input position, output coilA, output coilB);
    modport user_side  (output position, input coilA, input coilB);
endinterface : sds_coil_if

// >>> logic/sds_sine_table.sv
`timescale 1ns/100ps

module sds_sine_table
    import sds_pkg::*;
(
    // Clock and reset.
    input wire logic          mclk,
    input wire logic          rstn,
    // Table position in, coil currents out.
    sds_coil_if.table_side    coilBus
);

    // ****************************************
    // Quarter wave, built at elaboration
    // ****************************************
    // Only 257 amplitudes are stored; the other three quarters follow by symmetry.
    function automatic logic [7:0] quarterSine(input int idx);
        longint x;
        longint x2;
        longint term;
        longint acc;
        x    = (longint'(idx) * 64'sd205887) / 512;
        x2   = (x * x) >>> 16;
        term = x;
        acc  = x;
        term = -((term * x2) >>> 16) / 6;
        acc  = acc + term;
        term = -((term * x2) >>> 16) / 20;
        acc  = acc + term;
        term = -((term * x2) >>> 16) / 42;
        acc  = acc + term;
        term = -((term * x2) >>> 16) / 72;
        acc  = acc + term;
        acc  = (acc * 255 + 32768) >>> 16;
        if (acc > 255) begin
            acc = 255;
        end
        if (acc < 0) begin
            acc = 0;
        end
        return acc[7:0];
    endfunction : quarterSine

    logic [7:0] quarter [0:SDS_TABLE_QUARTER];

    for (genvar i = 0; i <= SDS_TABLE_QUARTER; i++) begin : g_quarter
        assign quarter[i] = quarterSine(i);
    end

    function automatic sds_coil_t coilValue(input sds_pos_t pos);
        logic [8:0] idx;
        logic [8:0] mag;
        idx = pos[8] ? (9'h100 - {1'b0, pos[7:0]}) : {1'b0, pos[7:0]};
        mag = {1'b0, quarter[idx]};
        return pos[9] ? -$signed(mag) : $signed(mag);
    endfunction : coilValue

    // ****************************************
    // Registered current vector
    // ****************************************
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            coilBus.coilA <= '0;
            coilBus.coilB <= '0;
        end else begin
            coilBus.coilA <= coilValue(coilBus.position); // see RULE4
            coilBus.coilB <= coilValue(sds_pos_t'(coilBus.position + 10'h100)); // see RULE4
        end
    end

endmodule : sds_sine_table

// >>> verif/sds_step_source.sv
`timescale 1ns/100ps

// ****************************************
// Step and direction source
// ****************************************
module sds_step_source (
    // Clock.
    input wire logic mclk,
    // Pins towards the sequencer.
    output logic     stepPin,
    output logic     dirPin
);
    initial begin
        stepPin = 1'b0;
        dirPin  = 1'b0;
    end

    // Too short a half period is raised, since the receiver would lose such steps.
    task automatic send(input int n, input int hp, input logic dir, input logic dedge);
        if (hp < (dedge ? 2 : 1)) begin
            hp = dedge ? 2 : 1;
        end
        @(posedge mclk);
        dirPin <= dir;
        repeat (3) @(posedge mclk);
        for (int i = 0; i < n; i++) begin
            if (dedge) begin
                stepPin <= ~stepPin;
                repeat (2 * hp) @(posedge mclk);
            end else begin
                stepPin <= 1'b1;
                repeat (hp) @(posedge mclk);
                stepPin <= 1'b0;
                repeat (hp) @(posedge mclk);
            end
        end
        // Direction is held well past the last edge.
        repeat (3) @(posedge mclk);
    endtask : send
endmodule : sds_step_source

// >>> verif/step_dir_microstep_sequencer_tb.sv
`timescale 1ns/100ps

// ****************************************
// Testbench
// ****************************************
module step_dir_microstep_sequencer_tb
    import sds_pkg::*;
;
    localparam int STILL = 2000;
    localparam int FAST  = 500;

    logic        mclk;
    logic        rstn;
    logic [7:0]  regAddr;
    logic [31:0] regWdata;
    logic        regWrite;
    logic        regRead;
    logic [31:0] regRdata;
    logic        stepPin;
    logic        dirPin;
    sds_coil_t   coilCurrentA;
    sds_coil_t   coilCurrentB;
    sds_scale_t  currentScale;
    sds_pos_t    microPosition;
    logic        standstill;
    sds_pos_t    expPos;
    int          bad_count;
    int          n_tests;

    sds_step_sequencer #(.STANDSTILL_CLKS(STILL), .FAST_STANDSTILL_CLKS(FAST)) dut (
        .mclk(mclk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .stepPin(stepPin), .dirPin(dirPin), .coilCurrentA(coilCurrentA),
        .coilCurrentB(coilCurrentB), .currentScale(currentScale),
        .microPosition(microPosition), .standstill(standstill));
    sds_step_source src (.mclk(mclk), .stepPin(stepPin), .dirPin(dirPin));

    always #4 mclk = ~mclk;

    task automatic end_sim();
        if (bad_count == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge mclk);
        regWrite <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge mclk);
        regRead <= 1'b0;
        #1;
        d = regRdata;
    endtask : rd

    task automatic go(input int n, input int w, input logic dir, input logic dedge);
        src.send(n, 2, dir, dedge);
        repeat (2) @(posedge mclk);
        expPos = dir ? expPos - sds_pos_t'(n * w) : expPos + sds_pos_t'(n * w);
        chk("microPosition", 32'(expPos), 32'(microPosition));
    endtask : go

    task automatic t_regs();
        logic [31:0] d;
        rd(SDS_ADDR_GLOBAL, d);
        chk("global", SDS_GLOBAL_RST, d);
        rd(SDS_ADDR_CHOPPER, d);
        chk("chopper", SDS_CHOPPER_RST, d);
        rd(SDS_ADDR_CURRENT, d);
        chk("current", SDS_CURRENT_RST, d);
        rd(8'h14, d);
        chk("unmapped", 32'h0, d);
        wr(SDS_ADDR_STATUS, 32'hffff_ffff);
        rd(SDS_ADDR_STATUS, d);
        chk("status", 32'h0, d);
        chk("currentScale", 32'h1f, 32'(currentScale));
    endtask : t_regs

    task automatic t_steps();
        wr(SDS_ADDR_CHOPPER, 32'h0);
        go(5, 1, 1'b0, 1'b0);
        go(3, 1, 1'b1, 1'b0);
        go(3, 1, 1'b1, 1'b0);
        wr(SDS_ADDR_CHOPPER, 32'h2000_0000);
        go(4, 1, 1'b1, 1'b1);
        go(2, 1, 1'b0, 1'b1);
    endtask : t_steps

    task automatic t_res();
        int        w;
        sds_coil_t mA;
        sds_coil_t mB;
        for (int r = 1; r <= 8; r++) begin
            w = 1 << r;
            wr(SDS_ADDR_CHOPPER, 32'(r) << SDS_CHOP_RES_LSB);
            repeat (2) @(posedge mclk);
            expPos = (expPos & ~sds_pos_t'(w - 1)) | sds_pos_t'(w / 2);
            chk("snap", 32'(expPos), 32'(microPosition));
            go(1, w, 1'b0, 1'b0);
            go(1, w, 1'b1, 1'b0);
            chk("cellPos", 32'(w / 2), 32'(microPosition & sds_pos_t'(w - 1)));
        end
        // Settings above full step must behave as full step.
        wr(SDS_ADDR_CHOPPER, 32'h0f00_0000);
        go(1, 256, 1'b0, 1'b0);
        chk("fullPos", 32'h80, 32'(microPosition & 10'h0ff));
        mA = coilCurrentA[8] ? -coilCurrentA : coilCurrentA;
        mB = coilCurrentB[8] ? -coilCurrentB : coilCurrentB;
        chk("coilMag", 32'(mA), 32'(mB));
        chk("coilOn", 32'h1, 32'(mA != 9'sd0));
        wr(SDS_ADDR_CHOPPER, 32'h0);
        go(1, 1, 1'b0, 1'b0);
    endtask : t_res

    task automatic t_interp();
        sds_pos_t dd;
        wr(SDS_ADDR_CHOPPER, 32'h1400_0000);
        repeat (2) @(posedge mclk);
        expPos = (expPos & ~10'h00f) | 10'h008;
        fork
            src.send(3, 32, 1'b0, 1'b0);
            begin
                repeat (101) @(posedge mclk);
                dd = microPosition - expPos - 10'd16;
                chk("interpMid", 32'h1, 32'(dd > 0 && dd < 16));
            end
        join
        repeat (20) @(posedge mclk);
        expPos = expPos + 10'd48;
        chk("interpEnd", 32'(expPos), 32'(microPosition));
        wr(SDS_ADDR_CHOPPER, 32'h0400_0000);
        go(1, 16, 1'b0, 1'b0);
    endtask : t_interp

    task automatic t_still();
        logic [31:0] d;
        wr(SDS_ADDR_CURRENT, 32'h0000_1503);
        wr(SDS_ADDR_CHOPPER, 32'h0);
        go(1, 1, 1'b0, 1'b0);
        repeat (STILL - 50) @(posedge mclk);
        chk("standstill", 32'h0, 32'(standstill));
        repeat (80) @(posedge mclk);
        chk("standstill", 32'h1, 32'(standstill));
        chk("holdScale", 32'h03, 32'(currentScale));
        rd(SDS_ADDR_STATUS, d);
        chk("statusStill", 32'h1, 32'(d[SDS_STAT_STILL_BIT]));
        go(1, 1, 1'b0, 1'b0);
        chk("standstill", 32'h0, 32'(standstill));
        chk("runScale", 32'h15, 32'(currentScale));
        wr(SDS_ADDR_GLOBAL, 32'h1);
        go(1, 1, 1'b0, 1'b0);
        repeat (FAST - 50) @(posedge mclk);
        chk("fastStill", 32'h0, 32'(standstill));
        repeat (80) @(posedge mclk);
        chk("fastStill", 32'h1, 32'(standstill));
    endtask : t_still

    initial begin
        mclk      = 1'b0;
        rstn      = 1'b0;
        regAddr   = 8'h00;
        regWdata  = 32'h0;
        regWrite  = 1'b0;
        regRead   = 1'b0;
        expPos    = 10'h000;
        bad_count = 0;
        n_tests   = 0;
        repeat (10) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        t_regs();
        t_steps();
        t_res();
        t_interp();
        t_still();
        end_sim();
    end

    // The whole run needs under 10000 cycles.
    initial begin
        repeat (40000) @(posedge mclk);
        bad_count++;
        end_sim();
    end
endmodule : step_dir_microstep_sequencer_tb
